//--- ebus_pkg.sv
// Purpose: constants and carriers for the external bus cycle end and hold arbitration block
// Assumes: one core clock; the clock output toggles from it
// Notes:   no register bus, all controls are ports
// Overview of operation
// - ready high at sampling point adds a wait state; low ends the cycle.
// - ready is looked at only after the programmed memory cycle waits run out.
// - strobe leading edge comes one state later when strobe delay is on.
// - multiplexed mode adds one turnaround wait, plus an optional tristate wait.
// - ready is taken directly or through a two-flop synchroniser, per mode.
// - a hold request lets the running bus cycle finish before the grant.
// - hold is sampled, grant and reclaim request change, on clock edges.
// - bus taken back only when hold goes inactive; then next cycle may start.
package ebus_pkg;
	localparam int          WAIT_W        = 4;
	localparam logic [3:0]  WAIT_ZERO     = 4'h0;
	localparam logic [3:0]  WAIT_ONE      = 4'h1;

	typedef enum logic [9:0] {
		ST_IDLE   = 10'h001,
		ST_ADDR   = 10'h002,
		ST_DELAY  = 10'h004,
		ST_WAIT   = 10'h008,
		ST_READY  = 10'h010,
		ST_MUXW   = 10'h020,
		ST_TRIW   = 10'h040,
		ST_FLOAT  = 10'h080,
		ST_HELD   = 10'h100,
		ST_REGAIN = 10'h200
	} bus_state_t;

	typedef struct packed {
		logic              multiplexed;
		logic              strobe_delay;
		logic              tristate_wait;
		logic              async_ready;
		logic [WAIT_W-1:0] wait_count;
	} bus_cfg_t;

	typedef struct packed {
		logic start;
		logic write;
		logic high_byte;
	} cycle_req_t;
endpackage

//--- ready_sync.sv
// Purpose: two-flop synchroniser for the asynchronous ready pin
// Assumes: input may change at any time
// Notes:   first flop feeds only the second
`timescale 1ns/100ps
module ready_sync (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// level in and out
	input  wire logic async_in_n,
	output logic      sync_out_n
);
	typedef struct packed {
		logic meta;
		logic stable;
	} sync_state_t;
	sync_state_t state;
	sync_state_t next_state;

	always_comb begin
		next_state.meta   = async_in_n;
		next_state.stable = state.meta;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= 2'h3;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out_n = state.stable;
endmodule

//--- ext_bus_ready_hold_arbitration.sv
// Purpose: external bus cycle sequencing with ready stretch and hold arbitration
// Assumes: one bus state per core clock; clock output is a divided copy
// Notes:   data path is outside; this block drives strobes and enables
`timescale 1ns/100ps
module ext_bus_ready_hold_arbitration
	import ebus_pkg::*;
(
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	// configuration
	input  wire ebus_pkg::bus_cfg_t   cfg,
	// cycle request from the core
	input  wire ebus_pkg::cycle_req_t req,
	input  wire logic                 need_bus,
	// external pins
	input  wire logic                 ready_n,
	input  wire logic                 hold_n,
	output logic                      system_clock_output,
	output logic                      addr_latch,
	output logic                      read_n,
	output logic                      write_n,
	output logic                      high_byte_select_n,
	output logic                      bus_oe_n,
	output logic                      hold_grant_out,
	output logic                      bus_reclaim_request_n,
	// status to the core
	output logic                      cycle_busy,
	output logic                      cycle_done
);
	import ebus_pkg::*;

	typedef struct packed {
		bus_state_t        st;
		logic [WAIT_W-1:0] waits;
		logic              wr;
		logic              hb;
		logic              clk_out;
		logic              ale;
		logic              rd_n;
		logic              wr_n;
		logic              bhe_n;
		logic              oe_n;
		logic              grant;
		logic              bus_reclaim_request_n_n;
		logic              busy;
		logic              done;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t n;
	logic       ready_synced_n;
	logic       ready_eff_n;
	logic       strobe_on;

	// ----------------------------------------
	// ready path
	// ----------------------------------------
	ready_sync u_ready_sync (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.async_in_n (ready_n),
		.sync_out_n (ready_synced_n)
	);

	// async path costs two cycles of latency but is safe against metastability
	assign ready_eff_n = cfg.async_ready ? ready_synced_n : ready_n;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		n           = s;
		n.clk_out   = ~s.clk_out;
		n.done      = 1'b0;
		n.ale       = 1'b0;
		strobe_on   = 1'b0;
		case (s.st)
			ST_IDLE: begin
				if (!hold_n) begin
					n.oe_n = 1'b1;
					n.st   = ST_FLOAT;
				end else if (req.start) begin
					n.st   = ST_ADDR;
					n.wr   = req.write;
					n.hb   = req.high_byte;
					n.busy = 1'b1;
					n.ale  = 1'b1;
					n.oe_n = 1'b0;
				end
			end
			ST_ADDR: begin
				n.waits = cfg.wait_count;
				n.st    = cfg.strobe_delay ? ST_DELAY : ST_WAIT;
				strobe_on = ~cfg.strobe_delay;
			end
			ST_DELAY: begin
				strobe_on = 1'b1;
				n.st      = ST_WAIT;
			end
			ST_WAIT: begin
				strobe_on = 1'b1;
				if (s.waits == WAIT_ZERO) begin
					n.st = ST_READY;
				end else begin
					n.waits = s.waits - WAIT_ONE;
				end
			end
			ST_READY: begin
				strobe_on = 1'b1;
				if (!ready_eff_n) begin
					n.rd_n = 1'b1;
					n.wr_n = 1'b1;
					strobe_on = 1'b0;
					n.done = 1'b1;
					n.busy = 1'b0;
					n.st   = cfg.multiplexed ? ST_MUXW
						: (cfg.tristate_wait ? ST_TRIW : ST_IDLE);
				end
			end
			ST_MUXW: begin
				n.st = cfg.tristate_wait ? ST_TRIW : ST_IDLE;
			end
			ST_TRIW: begin
				n.st = ST_IDLE;
			end
			ST_FLOAT: begin
				n.grant = 1'b1;
				n.st    = ST_HELD;
			end
			ST_HELD: begin
				if (hold_n) begin
					n.grant  = 1'b0;
					n.bus_reclaim_request_n_n = 1'b1;
					n.st     = ST_REGAIN;
				end else begin
					n.bus_reclaim_request_n_n = ~need_bus;
				end
			end
			ST_REGAIN: begin
				n.oe_n = 1'b0;
				n.st   = ST_IDLE;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		if (strobe_on) begin
			n.rd_n  = s.wr;
			n.wr_n  = ~s.wr;
		end
		n.bhe_n = ~s.hb;
	end

	// hold sampled only here, on clock edges; cycle never aborted by hold
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{st: ST_IDLE, waits: WAIT_ZERO, wr: 1'b0, hb: 1'b0, clk_out: 1'b0,
				ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, bhe_n: 1'b1, oe_n: 1'b0,
				grant: 1'b0, bus_reclaim_request_n_n: 1'b1, busy: 1'b0, done: 1'b0};
		end else begin
			s <= n;
		end
	end

	assign system_clock_output   = s.clk_out;
	assign addr_latch            = s.ale;
	assign read_n                = s.rd_n;
	assign write_n               = s.wr_n;
	assign high_byte_select_n    = s.bhe_n;
	assign bus_oe_n              = s.oe_n;
	assign hold_grant_out        = s.grant;
	assign bus_reclaim_request_n = s.bus_reclaim_request_n_n;
	assign cycle_busy            = s.busy;
	assign cycle_done            = s.done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_READY_HIGH_STRETCH: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_READY && ready_eff_n) |=> (s.st == ST_READY && !s.done))
		else $error("ready high did not stretch");
	AST_READY_LOW_ENDS: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_READY && !ready_eff_n) |=> (s.done && s.rd_n && s.wr_n))
		else $error("ready low did not end cycle");
	AST_WAIT_BEFORE_READY: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_WAIT && s.waits != WAIT_ZERO) |=> (s.st == ST_WAIT))
		else $error("ready sampled before waits ran out");
	AST_DELAY_STROBE: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_ADDR && cfg.strobe_delay) |=> (s.rd_n && s.wr_n) ##1 (!s.rd_n || !s.wr_n))
		else $error("delayed strobe timing wrong");
	AST_MUX_GAP: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_READY && !ready_eff_n && cfg.multiplexed) |=> (s.st == ST_MUXW))
		else $error("turnaround wait missing");
	AST_NO_GRANT_MID_CYCLE: assert property (@(posedge core_clk) disable iff (!reset_n)
		s.busy |-> !s.grant)
		else $error("bus granted during a cycle");
	AST_FLOAT_BEFORE_GRANT: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(s.grant) |-> (s.oe_n && $past(s.oe_n)))
		else $error("bus not floated before grant");
	AST_REGAIN_ON_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_HELD && hold_n) |=> (!s.grant && s.bus_reclaim_request_n_n) ##1 !s.oe_n)
		else $error("regain sequence wrong");
	AST_BUS_RECLAIM_REQUEST_N_ONLY_HELD: assert property (@(posedge core_clk) disable iff (!reset_n)
		!s.bus_reclaim_request_n_n |-> s.grant)
		else $error("reclaim request without grant");
	AST_HOLD_FLOATS_FIRST: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_IDLE && !hold_n) |=> (s.st == ST_FLOAT && s.oe_n && !s.grant) ##1 s.grant)
		else $error("idle hold did not float then grant");
	AST_BUS_RECLAIM_REQUEST_N_ON_NEED: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_HELD && !hold_n && need_bus) |=> !s.bus_reclaim_request_n_n)
		else $error("reclaim request not raised while held");
	// async ready reaches the sampling point two edges late
	AST_ASYNC_READY_LATE: assert property (@(posedge core_clk) disable iff (!reset_n)
		(s.st == ST_READY && cfg.async_ready && $past(ready_n, 2)) |=> (s.st == ST_READY))
		else $error("async ready used before it was synchronised");
	COV_STRETCH: cover property (@(posedge core_clk) disable iff (!reset_n)
		s.st == ST_READY ##1 s.st == ST_READY ##1 s.done);
	COV_GRANT: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(s.grant));
	COV_RECLAIM: cover property (@(posedge core_clk) disable iff (!reset_n)
		!s.bus_reclaim_request_n_n ##[1:50] !s.grant);
	COV_TRI: cover property (@(posedge core_clk) disable iff (!reset_n) s.st == ST_TRIW);
endmodule

//--- bus_far_side.sv
// Purpose: far side model, memory ready source and alternate master
// Assumes: ready line pulled up when nobody pulls it low
// Notes:   stall sets strobe-low cycles before ready
`timescale 1ns/100ps
module bus_far_side (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// strobes from the device
	input  wire logic       read_n,
	input  wire logic       write_n,
	// test controls
	input  wire logic [3:0] stall,
	input  wire logic       hold_req,
	// answers
	output logic            ready_n,
	output logic            hold_n
);
	logic [3:0] low_cnt;
	wire        strobe_low = !read_n || !write_n;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			low_cnt <= 4'h0;
		else if (!strobe_low)
			low_cnt <= 4'h0;
		else if (low_cnt != 4'hF)
			low_cnt <= low_cnt + 4'h1;
	end
	// held until the strobe rises, so async sync always sees it
	assign ready_n = !(strobe_low && low_cnt >= stall);
	// may drop the request unasked
	assign hold_n = !hold_req;
endmodule

//--- ext_bus_ready_hold_arbitration_tb.sv
// Purpose: self-checking bench for bus cycle end and hold arbitration
// Assumes: far side model answers ready and hold
// Notes:   latencies are relative to the plainest row
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module ext_bus_ready_hold_arbitration_tb;
	import ebus_pkg::*;
	logic       core_clk, reset_n, need_bus, hold_req, ready_n, hold_n, rd_seen, wr_seen;
	logic       system_clock_output, addr_latch, read_n, write_n, high_byte_select_n;
	logic       bus_oe_n, hold_grant_out, bus_reclaim_request_n, cycle_busy, cycle_done;
	bus_cfg_t   cfg;
	cycle_req_t req;
	logic [3:0] stall;
	logic [21:0] rows [8];
	int         n_errors, comparisons, n, m, base, gbase;
	ext_bus_ready_hold_arbitration DUT (.core_clk(core_clk), .reset_n(reset_n), .cfg(cfg),
		.req(req), .need_bus(need_bus), .ready_n(ready_n), .hold_n(hold_n),
		.system_clock_output(system_clock_output), .addr_latch(addr_latch), .read_n(read_n),
		.write_n(write_n), .high_byte_select_n(high_byte_select_n), .bus_oe_n(bus_oe_n),
		.hold_grant_out(hold_grant_out), .bus_reclaim_request_n(bus_reclaim_request_n),
		.cycle_busy(cycle_busy), .cycle_done(cycle_done));
	bus_far_side far (.core_clk(core_clk), .reset_n(reset_n), .read_n(read_n),
		.write_n(write_n), .stall(stall), .hold_req(hold_req), .ready_n(ready_n), .hold_n(hold_n));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task tick;
		@(posedge core_clk);
		#1;
	endtask
	function logic sel(int k);
		case (k)
			0: sel = cycle_done;
			1: sel = hold_grant_out;
			2: sel = bus_reclaim_request_n;
			3: sel = addr_latch;
			default: sel = bus_oe_n;
		endcase
	endfunction
	task final_report;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wt(input int k, input logic v, output int cnt);
		cnt = 0;
		while (sel(k) !== v) begin
			tick;
			cnt++;
			if (cnt > 60) begin
				`CHK("wait", v, sel(k))
				final_report;
			end
		end
	endtask
	// row: modes, waits, write/byte, stall, extra cycles, turnaround gap
	task run_row(input logic [21:0] r);
		cfg = r[21:14];
		stall = r[11:8];
		repeat (4) tick;
		req = {1'b1, r[13:12]};
		{rd_seen, wr_seen, n} = '0;
		do begin
			tick;
			req.start = 1'b0;
			n++;
			rd_seen |= !read_n;
			wr_seen |= !write_n;
			if (!read_n || !write_n) `CHK("byte_sel", !r[12], high_byte_select_n)
			if (n == 1) `CHK("busy_start", 2'h3, {cycle_busy, addr_latch})
		end while (cycle_done !== 1'b1 && n < 60);
		if (base < 0) base = n;
		`CHK("latency", base + r[7:4], n)
		if (n >= 60) final_report;
		`CHK("busy_end", 1'b0, cycle_busy)
		`CHK("read_strobe", !r[13], rd_seen)
		`CHK("write_strobe", r[13], wr_seen)
		req.start = 1'b1;
		wt(3, 1'b1, m);
		req.start = 1'b0;
		if (gbase < 0) gbase = m;
		`CHK("turnaround", gbase + r[3:0], m)
		wt(0, 1'b1, m);
	endtask
	initial begin
		{reset_n, cfg, req, need_bus, hold_req, stall, n_errors, comparisons} = '0;
		{base, gbase} = {-32'sd1, -32'sd1};
		// delay 4, mux 8, tristate 2, async 1
		rows = '{{4'h0, 4'h0, 2'h0, 4'h0, 4'h0, 4'h0}, {4'h4, 4'h0, 2'h3, 4'h0, 4'h1, 4'h0},
			{4'h0, 4'h3, 2'h1, 4'h0, 4'h3, 4'h0}, {4'h8, 4'h0, 2'h2, 4'h0, 4'h0, 4'h1},
			{4'hA, 4'h2, 2'h0, 4'h0, 4'h2, 4'h2}, {4'h0, 4'h0, 2'h0, 4'h3, 4'h2, 4'h0},
			{4'h1, 4'h0, 2'h2, 4'h0, 4'h1, 4'h0}, {4'h0, 4'h2, 2'h0, 4'h1, 4'h2, 4'h0}};
		repeat (6) tick;
		`CHK("rst_strobes", 2'h3, {read_n, write_n})
		`CHK("rst_arb", 3'h2, {hold_grant_out, bus_reclaim_request_n, bus_oe_n})
		`CHK("rst_clk_out", 1'b0, system_clock_output)
		reset_n = 1'b1;
		tick;
		`CHK("clk_out_hi", 1'b1, system_clock_output)
		tick;
		`CHK("clk_out_lo", 1'b0, system_clock_output)
		foreach (rows[i]) run_row(rows[i]);
		// hold arrives in a long cycle
		cfg = 8'h03;
		req = 3'h4;
		tick;
		req.start = 1'b0;
		hold_req = 1'b1;
		tick;
		`CHK("grant_in_cycle", 1'b0, hold_grant_out)
		wt(1, 1'b1, m);
		`CHK("floated_at_grant", 2'h3, {bus_oe_n, bus_reclaim_request_n})
		need_bus = 1'b1;
		req.start = 1'b1;
		wt(2, 1'b0, m);
		repeat (3) begin
			tick;
			`CHK("start_refused", 1'b0, addr_latch)
		end
		hold_req = 1'b0;
		wt(1, 1'b0, m);
		`CHK("regain_order", 2'h3, {bus_oe_n, bus_reclaim_request_n})
		need_bus = 1'b0;
		wt(3, 1'b1, m);
		`CHK("driven_again", 1'b0, bus_oe_n)
		req.start = 1'b0;
		wt(0, 1'b1, m);
		hold_req = 1'b1;
		wt(1, 1'b1, m);
		tick;
		hold_req = 1'b0;
		wt(1, 1'b0, m);
		`CHK("unasked_regain", 1'b1, bus_reclaim_request_n)
		wt(4, 1'b0, m);
		// reset in the middle of a cycle, then one plain cycle
		req.start = 1'b1;
		repeat (3) tick;
		`CHK("mid_strobe", 1'b0, read_n)
		reset_n = 1'b0;
		#1;
		`CHK("mid_rst", 3'h6, {read_n, write_n, cycle_busy})
		req.start = 1'b0;
		tick;
		reset_n = 1'b1;
		run_row(rows[0]);
		final_report;
	end
endmodule
